/* hdl/pmc_top.sv */
// Performance counters with overflow interrupt behind an AXI4-Lite slave
// Overview of operation
// - Stop clears enable; clear bit zeroes counters
// - Event counters wrap; masked wrap sets its flag but raises no interrupt
// - Four mask bits 0..3, reset zero
// - Wrap sets pending flag bits 8..11
// - Write one clears flag, zero ignored
// - Interrupt when any flag and mask set
// - Cycle counter overflow never raises interrupt
// - In idle only idle-event counters increment
// - Enable bit starts all counters
// - Clear bit zeroes all, reads zero
// - Four 7-bit event selects, reset zero
// - Read or write drops same-cycle increment
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_top
    import pmc_pkg::*;
#(
    parameter int NUM_EVENTS = 128
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_EVENTS-1:0] event_vec,
    input wire logic idle_mode,
    output logic perf_irq
);

    pmc_state_s st_r;
    pmc_state_s st_nxt;

    logic ar_take;
    logic commit;
    logic [7:0] ar_word;
    logic [7:0] w_word;
    logic [31:0] ctl_word;
    logic [31:0] irq_word;
    logic [31:0] rd_val;
    logic rd_ok;
    logic [31:0] wd_ctl;
    logic [31:0] wd_irq;
    logic wr_ctl;
    logic wr_irq;
    logic wr_clr;
    logic [3:0] hit_rd;
    logic [3:0] hit_wr;
    logic [3:0] inc;
    logic [3:0] wrap;

    function automatic logic [31:0] pmc_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction

    assign ar_take = s_axi_arvalid && st_r.arready;
    assign commit = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    assign ar_word = {s_axi_araddr[7:2], 2'h0};
    assign w_word = {st_r.awaddr[7:2], 2'h0};
    assign ctl_word = {st_r.sel, 1'h0, st_r.idle_seen, 1'h0, st_r.en};
    assign irq_word = {20'h0, st_r.pend, 4'h0, st_r.mask};
    assign wd_ctl = pmc_merge(ctl_word, st_r.wdata, st_r.wstrb);
    assign wd_irq = pmc_merge(irq_word, st_r.wdata, st_r.wstrb);
    assign wr_ctl = commit && (w_word == `PMC_OFF_CTL);
    assign wr_irq = commit && (w_word == `PMC_OFF_IRQ);
    assign wr_clr = wr_ctl && st_r.wstrb[0] && st_r.wdata[`PMC_CTL_CLR];

    // Per-counter access hits, increment qualifiers and wraps
    for (genvar i = 0; i < 4; i++) begin : g_cnt
        localparam logic [7:0] OFF = 8'(`PMC_OFF_CNT0 + i * `PMC_CNT_STRIDE);
        logic ev;
        assign ev = event_vec[st_r.sel[i]];
        assign hit_rd[i] = ar_take && (ar_word == OFF);
        assign hit_wr[i] = commit && (w_word == OFF);
        assign inc[i] = st_r.en
            && ev
            && (!idle_mode || st_r.sel[i] == `PMC_IDLE_EVENT)
            && !hit_rd[i] && !hit_wr[i];
        assign wrap[i] = inc[i] && (&st_r.cnt[i]);
    end

    // Read data decode
    always_comb begin
        rd_val = 32'h0;
        rd_ok = 1'b1;
        unique case (ar_word)
            `PMC_OFF_CTL: rd_val = ctl_word;
            `PMC_OFF_IRQ: rd_val = irq_word;
            `PMC_OFF_CYC_LO: rd_val = st_r.cyc[31:0];
            `PMC_OFF_CYC_HI: rd_val = st_r.cyc[63:32];
            default: begin
                rd_ok = 1'b0;
                for (int i = 0; i < 4; i++) begin
                    if (hit_rd[i]) begin
                        rd_val = st_r.cnt[i];
                        rd_ok = 1'b1;
                    end
                end
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        // Read channel
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (ar_take) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_val;
            st_nxt.rresp = rd_ok ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
        end
        st_nxt.arready = !st_nxt.rvalid;
        // Write address and data, taken in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (commit) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `PMC_RESP_OKAY;
            if (w_word == `PMC_OFF_CYC_LO || w_word == `PMC_OFF_CYC_HI) begin
                st_nxt.bresp = `PMC_RESP_OKAY;
            end else if (!wr_ctl && !wr_irq && hit_wr == 4'h0) begin
                st_nxt.bresp = `PMC_RESP_SLVERR;
            end
        end
        st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
        st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;
        // Event counters; a write replaces the strobed bytes of the count
        for (int i = 0; i < 4; i++) begin
            if (inc[i]) begin
                st_nxt.cnt[i] = st_r.cnt[i] + 32'h1;
            end
            if (hit_wr[i]) begin
                st_nxt.cnt[i] = pmc_merge(st_r.cnt[i], st_r.wdata, st_r.wstrb);
            end
        end
        // Cycle counter, halted in idle; its carry-out is dropped
        if (st_r.en && !idle_mode) begin
            st_nxt.cyc = st_r.cyc + 64'h1;
        end
        // Control register
        if (wr_ctl) begin
            st_nxt.en = wd_ctl[`PMC_CTL_EN];
            st_nxt.sel = wd_ctl[31:`PMC_CTL_SEL_LSB];
            if (st_r.wstrb[0] && st_r.wdata[`PMC_CTL_IDLE]) begin
                st_nxt.idle_seen = 1'b0;
            end
        end
        if (wr_clr) begin
            st_nxt.cnt = '0;
            st_nxt.cyc = 64'h0;
        end
        if (idle_mode) begin
            st_nxt.idle_seen = 1'b1;
        end
        // Overflow mask and pending flags; a wrap wins over a clear
        if (wr_irq) begin
            st_nxt.mask = wd_irq[`PMC_IRQ_MASK_LSB +: 4];
            st_nxt.pend = st_r.pend & ~(st_r.wdata[`PMC_IRQ_PEND_LSB +: 4]
                & {4{st_r.wstrb[1]}});
        end
        st_nxt.pend = st_nxt.pend | wrap;
        st_nxt.irq = |(st_nxt.pend & st_nxt.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign perf_irq = st_r.irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence aw_taken_s;
        s_axi_awvalid && s_axi_awready;
    endsequence

    sequence w_taken_s;
        s_axi_wvalid && s_axi_wready;
    endsequence

    sequence both_taken_s;
        aw_taken_s and w_taken_s;
    endsequence

    irq_level_a: assert property (
        perf_irq == |(st_r.pend & st_r.mask))
        else $error("Interrupt output does not match flags and mask");

    reset_clear_a: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> st_r.mask == 4'h0 && st_r.pend == 4'h0 && st_r.sel == '0)
        else $error("Mask, flags or selects not zero after reset");

    for (genvar i = 0; i < 4; i++) begin : g_chk
        wrap_flag_a: assert property (
            wrap[i] |=> st_r.cnt[i] == 32'h0 && st_r.pend[i])
            else $error("Counter wrap did not zero count and set flag");

        flag_cause_a: assert property (
            $rose(st_r.pend[i]) |-> $past(wrap[i]))
            else $error("Flag set without a counter wrap");

        drop_inc_a: assert property (
            hit_rd[i] && !hit_wr[i] && !wr_clr |=> $stable(st_r.cnt[i]))
            else $error("Counter changed in its read cycle");

        cnt_hold_a: assert property (
            !st_r.en && !hit_wr[i] && !wr_clr
            |=> $stable(st_r.cnt[i]))
            else $error("Counter moved while disabled");

        inc_step_a: assert property (
            inc[i] && !wr_clr
            |=> st_r.cnt[i] == $past(st_r.cnt[i]) + 32'h1)
            else $error("Counter did not step by one on its event");

        idle_hold_a: assert property (
            idle_mode && st_r.sel[i] != `PMC_IDLE_EVENT && !hit_wr[i] && !wr_clr
            |=> $stable(st_r.cnt[i]))
            else $error("Counter moved during idle mode");
    end

    flag_clear_a: assert property (
        wr_irq && st_r.wstrb[1] && st_r.wdata[`PMC_IRQ_PEND_LSB] && !wrap[0]
        |=> !st_r.pend[0])
        else $error("Pending flag not cleared by writing one");

    flag_keep_a: assert property (
        st_r.pend[0] && !(wr_irq && st_r.wdata[`PMC_IRQ_PEND_LSB])
        |=> st_r.pend[0])
        else $error("Pending flag lost without a clearing write");

    mask_write_a: assert property (
        wr_irq && st_r.wstrb[0]
        |=> st_r.mask == $past(st_r.wdata[`PMC_IRQ_MASK_LSB +: 4]))
        else $error("Mask bits not taken from the written word");

    sel_write_a: assert property (
        wr_ctl && (&st_r.wstrb)
        |=> st_r.sel == $past(st_r.wdata[31:`PMC_CTL_SEL_LSB]))
        else $error("Event selects not taken from the written word");

    en_write_a: assert property (
        wr_ctl && st_r.wstrb[0]
        |=> st_r.en == $past(st_r.wdata[`PMC_CTL_EN]))
        else $error("Enable bit not taken from the written word");

    cyc_idle_a: assert property (
        idle_mode && !wr_clr
        |=> $stable(st_r.cyc))
        else $error("Cycle counter ran in idle mode");

    cyc_count_a: assert property (
        st_r.en && !idle_mode && !wr_clr
        |=> st_r.cyc == $past(st_r.cyc) + 64'h1)
        else $error("Cycle counter did not step while enabled");

    clear_all_a: assert property (
        wr_clr |=> st_r.cnt == '0 && st_r.cyc == 64'h0)
        else $error("Clear bit did not zero all counters");

    clr_reads_zero_a: assert property (
        ar_take && ar_word == `PMC_OFF_CTL |=> !s_axi_rdata[`PMC_CTL_CLR])
        else $error("Clear bit read back as one");

    cyc_stop_a: assert property (
        !st_r.en && !wr_ctl |=> $stable(st_r.cyc))
        else $error("Cycle counter ran while disabled");

    cyc_no_irq_a: assert property (
        wrap == 4'h0 && !wr_irq
        |=> st_r.pend == $past(st_r.pend))
        else $error("Cycle counter carry touched the flags");

    write_resp_a: assert property (
        both_taken_s |-> ##2 s_axi_bvalid)
        else $error("Write response late");

    read_resp_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("Read data not one cycle after address");

endmodule // pmc_top
`default_nettype wire

/* hdl/pmc_regs.svh */
// Register offsets, field positions and codes of the performance counter block
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_OFF_CTL 8'h00
`define PMC_OFF_IRQ 8'h04
`define PMC_OFF_CNT0 8'h08
`define PMC_OFF_CYC_LO 8'h18
`define PMC_OFF_CYC_HI 8'h1c
`define PMC_CNT_STRIDE 8'h04
`define PMC_CTL_EN 0
`define PMC_CTL_CLR 1
`define PMC_CTL_IDLE 2
`define PMC_CTL_SEL_LSB 4
`define PMC_IRQ_MASK_LSB 0
`define PMC_IRQ_PEND_LSB 8
`define PMC_IDLE_EVENT 7'h1e
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2
`endif

/* hdl/pmc_pkg.sv */
// Types of the performance counter block
package pmc_pkg;
    typedef logic [6:0] pmc_sel_t;
    typedef struct packed {
        logic en;
        logic idle_seen;
        logic [3:0][6:0] sel;
        logic [3:0] mask;
        logic [3:0] pend;
        logic [3:0][31:0] cnt;
        logic [63:0] cyc;
        logic aw_held;
        logic w_held;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
    } pmc_state_s;
endpackage

/* sim/pmc_core_model.sv */
// Core-side model: event source, idle indication and interrupt sink
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
    input wire logic aclk,
    input wire logic perf_irq,
    output logic [127:0] event_vec,
    output logic idle_mode
);
    int irq_rises;
    logic irq_q;
    initial begin
        event_vec = '0;
        idle_mode = 1'b0;
        irq_rises = 0;
        irq_q = 1'b0;
    end
    // Interrupt controller sees rising requests
    always @(posedge aclk) begin
        if (perf_irq === 1'b1 && irq_q !== 1'b1) begin
            irq_rises <= irq_rises + 1;
        end
        irq_q <= perf_irq;
    end
    // Events high for n edges; call just after an edge
    task automatic burst(input logic [127:0] v, input logic idle, input int n);
        event_vec <= v;
        idle_mode <= idle;
        repeat (n) @(posedge aclk);
        event_vec <= '0;
        idle_mode <= 1'b0;
    endtask
endmodule // pmc_core_model
`default_nettype wire

/* sim/pmc_top_tb.sv */
// Self-checking bench of the performance counter block
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_top_tb;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, perf_irq;
    logic [1:0] bresp, rresp, rs;
    logic [127:0] event_vec;
    logic idle_mode;
    logic [6:0] b;
    logic [31:0] sels, v, c0;
    int n_fail = 0, num_checks = 0, seed = 16078;
    always #25 aclk = ~aclk;
    pmc_top u_pmc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .event_vec(event_vec), .idle_mode(idle_mode),
        .perf_irq(perf_irq));
    pmc_core_model u_pmc_core_model (.aclk(aclk), .perf_irq(perf_irq),
        .event_vec(event_vec), .idle_mode(idle_mode));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Write one word; waits for the response
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && t < 100);
        rs = bresp;
        bready <= 1'b0;
        if (t >= 100) n_fail++;
        @(posedge aclk);
    endtask
    task automatic axr(input logic [7:0] a);
        int t;
        t = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && t < 100);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (t >= 100) n_fail++;
        @(posedge aclk);
    endtask
    function automatic logic [31:0] cnt_addr(input int i);
        return `PMC_OFF_CNT0 + 32'(i) * `PMC_CNT_STRIDE;
    endfunction
    initial begin
        #(50 * 20000);
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(`PMC_OFF_CTL);
        chk(rd, 32'h0, "ctl reset");
        axr(`PMC_OFF_IRQ);
        chk(rd, 32'h0, "irq reset");
        axr(8'hfc);
        chk(rd, 32'h0, "unmapped read");
        chk(32'(rs), 32'(`PMC_RESP_SLVERR), "unmapped read resp");
        axw(8'hfc, 32'hffffffff);
        chk(32'(rs), 32'(`PMC_RESP_SLVERR), "unmapped write resp");
        $display("test reset done");
        b = 7'h40 | 7'($random(seed) & 32'h1f);
        sels = {`PMC_IDLE_EVENT, b + 7'h2, b + 7'h1, b, 4'h0};
        repeat (4) begin
            v = $random(seed);
            axw(8'(cnt_addr(2)), v);
            chk(32'(rs), 32'(`PMC_RESP_OKAY), "cnt2 write resp");
            axr(8'(cnt_addr(2)));
            chk(rd, v, "cnt2 rw");
        end
        wstrb <= 4'h3;
        axw(8'(cnt_addr(2)), ~v);
        wstrb <= 4'hf;
        axr(8'(cnt_addr(2)));
        chk(rd, {v[31:16], ~v[15:0]}, "cnt2 byte merge");
        axw(`PMC_OFF_CTL, sels | 32'h2);
        axw(8'(cnt_addr(0)), 32'hfffffffd);
        axw(`PMC_OFF_CTL, sels | 32'h1);
        axr(`PMC_OFF_CTL);
        chk(rd, sels | 32'h1, "ctl readback");
        $display("test setup done");
        u_pmc_core_model.burst(128'h1 << b, 1'b0, 3);
        axr(8'(cnt_addr(0)));
        chk(32'(perf_irq), 32'h0, "masked wrap irq");
        chk(rd, 32'h0, "cnt0 wrapped");
        axr(`PMC_OFF_IRQ);
        chk(rd, 32'h100, "flag0 set");
        axw(`PMC_OFF_IRQ, 32'h1);
        chk(32'(perf_irq), 32'h1, "irq raised");
        axw(`PMC_OFF_IRQ, 32'h1);
        axr(`PMC_OFF_IRQ);
        chk(rd, 32'h101, "zero keeps flag");
        axw(`PMC_OFF_IRQ, 32'h101);
        chk(32'(perf_irq), 32'h0, "irq dropped");
        axr(`PMC_OFF_IRQ);
        chk(rd, 32'h1, "one clears flag");
        chk(32'(u_pmc_core_model.irq_rises), 32'h1, "irq rises");
        $display("test overflow done");
        u_pmc_core_model.burst((128'h7 << b) | (128'h1 << `PMC_IDLE_EVENT), 1'b1, 4);
        axr(8'(cnt_addr(1)));
        chk(rd, 32'h0, "idle cnt1 held");
        axr(8'(cnt_addr(3)));
        chk(rd, 32'h4, "idle cnt3 counts");
        axr(`PMC_OFF_CTL);
        chk(rd, sels | 32'h5, "idle seen");
        $display("test idle done");
        fork
            u_pmc_core_model.burst(128'h1 << (b + 7'h1), 1'b0, 6);
            axr(8'(cnt_addr(1)));
        join
        chk(rd, 32'h0, "read cnt1 in burst");
        axr(8'(cnt_addr(1)));
        chk(rd, 32'h5, "read drops increment");
        axr(`PMC_OFF_CYC_HI);
        chk(rd, 32'h0, "cycle high");
        axr(`PMC_OFF_CYC_LO);
        c0 = rd;
        axr(`PMC_OFF_CYC_LO);
        chk(32'(rd > c0), 32'h1, "cycle runs");
        $display("test access done");
        axw(`PMC_OFF_CTL, sels);
        axr(`PMC_OFF_CYC_LO);
        c0 = rd;
        axw(`PMC_OFF_CYC_LO, ~c0);
        chk(32'(rs), 32'(`PMC_RESP_OKAY), "cycle write resp");
        u_pmc_core_model.burst(128'h1 << (b + 7'h1), 1'b0, 2);
        axr(8'(cnt_addr(1)));
        chk(rd, 32'h5, "stopped cnt1");
        axr(`PMC_OFF_CYC_LO);
        chk(rd, c0, "cycle stopped");
        axw(`PMC_OFF_CTL, sels | 32'h6);
        axr(8'(cnt_addr(3)));
        chk(rd, 32'h0, "clear zeroes");
        axr(`PMC_OFF_CYC_LO);
        chk(rd, 32'h0, "clear cycle low");
        axr(`PMC_OFF_CTL);
        chk(rd, sels, "clear and idle bits");
        $display("test stop done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(`PMC_OFF_IRQ);
        chk(rd, 32'h0, "irq after reset");
        axr(`PMC_OFF_CTL);
        chk(rd, 32'h0, "ctl after reset");
        $display("test reset again done");
        complete_run();
    end
endmodule // pmc_top_tb
`default_nettype wire
